/* File: rtl/srx_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "srx_regs.svh"

module srx_core
	import srx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] mem_rdata,
	input wire logic nonmaskable_ext_interrupt,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_rw,
	output logic [7:0] accumulator_one,
	output logic [7:0] accumulator_two,
	output logic [7:0] condition_code_register,
	output logic [15:0] index_x,
	output logic [15:0] index_y,
	output logic [15:0] stack_pointer,
	output logic [15:0] program_counter,
	output logic instr_done
);

	// ------------------------------------------------------------------
	// State record
	// ------------------------------------------------------------------
	typedef struct packed {
		srx_state_type st;
		srx_kind_type kind;
		logic pre_y;
		logic use_b;
		logic mem_form;
		logic indexed;
		logic [3:0] step;
		logic [15:0] ea;
		logic [7:0] tmp;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic rw;
		logic done;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] cc;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] sp;
		logic [15:0] pc;
	} srx_core_state_type;

	srx_core_state_type s_r;
	srx_core_state_type s_nxt;

	logic [7:0] rot_in;
	logic rot_right;
	logic [7:0] rot_res;
	logic rot_n;
	logic rot_z;
	logic rot_v;
	logic rot_c;
	logic [7:0] sub_res;
	logic [15:0] sp_inc;

	// ------------------------------------------------------------------
	// Shared rotate unit
	// ------------------------------------------------------------------
	// Memory forms rotate the latched operand. Register forms rotate A or B
	// during decode, where the opcode still sits in tmp and picks both the
	// accumulator and the direction, so they finish in two cycles.
	assign rot_in = s_r.mem_form ? s_r.tmp : (s_r.tmp[4] ? s_r.b : s_r.a);
	assign rot_right = (s_r.st == SRX_DECODE) ? ~s_r.tmp[3]
		: (s_r.kind == SRX_K_ROTR);
	assign sub_res = s_r.a - s_r.b;
	assign sp_inc = s_r.sp + 16'h0001;

	srx_rotate u_rot (
		.operand(rot_in),
		.carry_in(s_r.cc[`SRX_CC_C]),
		.dir_right(rot_right),
		.result(rot_res),
		.n_flag(rot_n),
		.z_flag(rot_z),
		.v_flag(rot_v),
		.c_flag(rot_c)
	);

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// Each state is one bus cycle; addr and rw are set for the next cycle.
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.rw = 1'b1;
		s_nxt.wdata = 8'h00;
		case (s_r.st)
			SRX_FETCH: begin
				// Opcode byte on the bus at addr this cycle.
				s_nxt.pc = s_r.pc + 16'h0001;
				s_nxt.addr = s_r.pc + 16'h0001;
				s_nxt.mem_form = 1'b0;
				s_nxt.indexed = 1'b0;
				s_nxt.use_b = 1'b0;
				s_nxt.kind = SRX_K_NONE;
				s_nxt.step = 4'h0;
				s_nxt.st = SRX_DECODE;
				if (mem_rdata == `SRX_OP_PREBYTE && !s_r.pre_y) begin
					s_nxt.pre_y = 1'b1;
					s_nxt.st = SRX_FETCH;
				end else begin
					s_nxt.tmp = mem_rdata;
				end
			end
			SRX_DECODE: begin
				// Second cycle: operand byte or idle read at opcode plus one.
				case (s_r.tmp)
					`SRX_OP_ROTL_A, `SRX_OP_ROTL_B,
					`SRX_OP_ROTR_A, `SRX_OP_ROTR_B: begin
						// Register forms end here, in their second cycle.
						if (s_r.tmp[4]) begin
							s_nxt.b = rot_res;
						end else begin
							s_nxt.a = rot_res;
						end
						s_nxt.cc[`SRX_CC_N] = rot_n;
						s_nxt.cc[`SRX_CC_Z] = rot_z;
						s_nxt.cc[`SRX_CC_V] = rot_v;
						s_nxt.cc[`SRX_CC_C] = rot_c;
						s_nxt.addr = s_r.pc;
						s_nxt.done = 1'b1;
						s_nxt.pre_y = 1'b0;
						s_nxt.st = SRX_FETCH;
					end
					`SRX_OP_ROTL_EXT, `SRX_OP_ROTR_EXT: begin
						s_nxt.kind = s_r.tmp[3] ? SRX_K_ROTL
							: SRX_K_ROTR;
						s_nxt.mem_form = 1'b1;
						s_nxt.ea = {mem_rdata, 8'h00};
						s_nxt.pc = s_r.pc + 16'h0001;
						s_nxt.addr = s_r.pc + 16'h0001;
						s_nxt.st = SRX_ADDR_LO;
					end
					`SRX_OP_ROTL_IDX, `SRX_OP_ROTR_IDX: begin
						s_nxt.kind = s_r.tmp[3] ? SRX_K_ROTL
							: SRX_K_ROTR;
						s_nxt.mem_form = 1'b1;
						s_nxt.indexed = 1'b1;
						s_nxt.ea = (s_r.pre_y ? s_r.y : s_r.x)
							+ {8'h00, mem_rdata};
						s_nxt.pc = s_r.pc + 16'h0001;
						s_nxt.addr = `SRX_DUMMY_ADDR;
						s_nxt.st = SRX_IDLE_RD;
					end
					`SRX_OP_PULL_IDX, `SRX_OP_RET_INT, `SRX_OP_RTS: begin
						s_nxt.kind = (s_r.tmp == `SRX_OP_RET_INT) ? SRX_K_RET_INT :
							(s_r.tmp == `SRX_OP_RTS) ? SRX_K_RTS : SRX_K_PULL_Y;
						s_nxt.addr = s_r.sp;
						s_nxt.st = SRX_STACK;
					end
					`SRX_OP_SUB_BA: begin
						s_nxt.a = sub_res;
						s_nxt.cc[`SRX_CC_N] = sub_res[7];
						s_nxt.cc[`SRX_CC_Z] = (sub_res == 8'h00);
						s_nxt.cc[`SRX_CC_V] = (s_r.a[7] & ~s_r.b[7] & ~sub_res[7])
							| (~s_r.a[7] & s_r.b[7] & sub_res[7]);
						s_nxt.cc[`SRX_CC_C] = (~s_r.a[7] & s_r.b[7])
							| (s_r.b[7] & sub_res[7])
							| (sub_res[7] & ~s_r.a[7]);
						s_nxt.addr = s_r.pc;
						s_nxt.done = 1'b1;
						s_nxt.pre_y = 1'b0;
						s_nxt.st = SRX_FETCH;
					end
					default: begin
						// Opcodes outside this group are treated as a no-op.
						s_nxt.addr = s_r.pc;
						s_nxt.done = 1'b1;
						s_nxt.pre_y = 1'b0;
						s_nxt.st = SRX_FETCH;
					end
				endcase
			end
			SRX_ADDR_LO: begin
				s_nxt.ea = {s_r.ea[15:8], mem_rdata};
				s_nxt.pc = s_r.pc + 16'h0001;
				s_nxt.addr = {s_r.ea[15:8], mem_rdata};
				s_nxt.st = SRX_OPER_RD;
			end
			SRX_IDLE_RD: begin
				// Indexed forms idle at the dummy address before the operand.
				s_nxt.addr = s_r.ea;
				s_nxt.st = SRX_OPER_RD;
			end
			SRX_OPER_RD: begin
				s_nxt.tmp = mem_rdata;
				s_nxt.addr = `SRX_DUMMY_ADDR;
				s_nxt.step = 4'h0;
				s_nxt.st = SRX_DUMMY2;
			end
			SRX_DUMMY2: begin
				// The prebyte fetch already gives the Y form its extra cycle,
				// so every memory form writes right after one dummy read.
				s_nxt.addr = s_r.ea;
				s_nxt.wdata = rot_res;
				s_nxt.rw = 1'b0;
				s_nxt.st = SRX_WRITE;
			end
			SRX_WRITE: begin
				// Write cycle of a memory rotate: commit the flags with it.
				s_nxt.cc[`SRX_CC_N] = rot_n;
				s_nxt.cc[`SRX_CC_Z] = rot_z;
				s_nxt.cc[`SRX_CC_V] = rot_v;
				s_nxt.cc[`SRX_CC_C] = rot_c;
				s_nxt.addr = s_r.pc;
				s_nxt.done = 1'b1;
				s_nxt.pre_y = 1'b0;
				s_nxt.st = SRX_FETCH;
			end
			SRX_STACK: begin
				// Step 0 is the idle read at SP; later steps pull bytes.
				if (s_r.step != 4'h0) begin
					s_nxt.sp = sp_inc;
					case (s_r.kind)
						SRX_K_RET_INT: begin
							case (s_r.step)
								4'h1: begin
									s_nxt.cc = mem_rdata;
									s_nxt.cc[`SRX_CC_X] = mem_rdata[`SRX_CC_X]
										& s_r.cc[`SRX_CC_X];
								end
								4'h2: s_nxt.b = mem_rdata;
								4'h3: s_nxt.a = mem_rdata;
								4'h4: s_nxt.x[15:8] = mem_rdata;
								4'h5: s_nxt.x[7:0] = mem_rdata;
								4'h6: s_nxt.y[15:8] = mem_rdata;
								4'h7: s_nxt.y[7:0] = mem_rdata;
								4'h8: s_nxt.pc[15:8] = mem_rdata;
								default: s_nxt.pc[7:0] = mem_rdata;
							endcase
						end
						SRX_K_RTS: begin
							if (s_r.step == 4'h1) begin
								s_nxt.pc[15:8] = mem_rdata;
							end else begin
								s_nxt.pc[7:0] = mem_rdata;
							end
						end
						default: begin
							if (s_r.step == 4'h1) begin
								s_nxt.y[15:8] = mem_rdata;
							end else begin
								s_nxt.y[7:0] = mem_rdata;
							end
						end
					endcase
				end
				s_nxt.step = s_r.step + 4'h1;
				// SP moves before the address, so the next pull is new SP plus one.
				s_nxt.addr = s_nxt.sp + 16'h0001;
				// Last pull: 9 bytes for interrupt return, 2 otherwise.
				if ((s_r.kind == SRX_K_RET_INT && s_r.step == 4'h9)
					|| (s_r.kind != SRX_K_RET_INT && s_r.step == 4'h2)) begin
					s_nxt.addr = (s_r.kind == SRX_K_PULL_Y) ? s_r.pc
						: {s_nxt.pc[15:8], mem_rdata};
					s_nxt.done = 1'b1;
					s_nxt.pre_y = 1'b0;
					s_nxt.st = SRX_FETCH;
				end
			end
			default: begin
				s_nxt.st = SRX_FETCH;
				s_nxt.addr = s_r.pc;
			end
		endcase
		// Interrupt recognition comes last so that it wins over a pulled byte.
		if (nonmaskable_ext_interrupt) begin
			s_nxt.cc[`SRX_CC_X] = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Reset forces X and I set; only reset or the nonmaskable interrupt
	// may raise X.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.st <= SRX_FETCH;
			s_r.kind <= SRX_K_NONE;
			s_r.rw <= 1'b1;
			s_r.cc <= `SRX_RESET_CC;
			s_r.sp <= `SRX_RESET_SP;
			s_r.pc <= `SRX_RESET_PC;
			s_r.addr <= `SRX_RESET_PC;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mem_addr = s_r.addr;
	assign mem_wdata = s_r.wdata;
	assign mem_rw = s_r.rw;
	assign accumulator_one = s_r.a;
	assign accumulator_two = s_r.b;
	assign condition_code_register = s_r.cc;
	assign index_x = s_r.x;
	assign index_y = s_r.y;
	assign stack_pointer = s_r.sp;
	assign program_counter = s_r.pc;
	assign instr_done = s_r.done;

endmodule

`default_nettype wire

/* File: rtl/srx_regs.svh */
`ifndef SRX_REGS_SVH
`define SRX_REGS_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SRX_OP_PREBYTE 8'h18
`define SRX_OP_PULL_IDX 8'h38
`define SRX_OP_ROTL_A 8'h49
`define SRX_OP_ROTL_B 8'h59
`define SRX_OP_ROTL_EXT 8'h79
`define SRX_OP_ROTL_IDX 8'h69
`define SRX_OP_ROTR_A 8'h46
`define SRX_OP_ROTR_B 8'h56
`define SRX_OP_ROTR_EXT 8'h76
`define SRX_OP_ROTR_IDX 8'h66
`define SRX_OP_RET_INT 8'h3B
`define SRX_OP_RTS 8'h39
`define SRX_OP_SUB_BA 8'h10

// ----------------------------------------------------------------------
// Condition-code bit positions and fixed addresses
// ----------------------------------------------------------------------
`define SRX_CC_S 7
`define SRX_CC_X 6
`define SRX_CC_H 5
`define SRX_CC_I 4
`define SRX_CC_N 3
`define SRX_CC_Z 2
`define SRX_CC_V 1
`define SRX_CC_C 0
`define SRX_DUMMY_ADDR 16'hFFFF
`define SRX_RESET_CC 8'hD0
`define SRX_RESET_SP 16'h00FF
`define SRX_RESET_PC 16'h0000

`endif

/* File: rtl/srx_pkg.sv */
package srx_pkg;

	// One-hot execution states.
	typedef enum logic [8:0] {
		SRX_FETCH = 9'h001,
		SRX_DECODE = 9'h002,
		SRX_ADDR_HI = 9'h004,
		SRX_ADDR_LO = 9'h008,
		SRX_IDLE_RD = 9'h010,
		SRX_OPER_RD = 9'h020,
		SRX_DUMMY2 = 9'h040,
		SRX_WRITE = 9'h080,
		SRX_STACK = 9'h100
	} srx_state_type;

	typedef enum logic [2:0] {
		SRX_K_NONE = 3'h0,
		SRX_K_ROTL = 3'h1,
		SRX_K_ROTR = 3'h2,
		SRX_K_PULL_Y = 3'h3,
		SRX_K_RET_INT = 3'h4,
		SRX_K_RTS = 3'h5
	} srx_kind_type;

endpackage

/* File: rtl/srx_rotate.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Rotate through carry with flag update
// ----------------------------------------------------------------------
module srx_rotate (
	input wire logic [7:0] operand,
	input wire logic carry_in,
	input wire logic dir_right,
	output logic [7:0] result,
	output logic n_flag,
	output logic z_flag,
	output logic v_flag,
	output logic c_flag
);

	// Both directions share the N, Z and V logic so the two forms never drift.
	always_comb begin
		if (dir_right) begin
			result = {carry_in, operand[7:1]};
			c_flag = operand[0];
		end else begin
			result = {operand[6:0], carry_in};
			c_flag = operand[7];
		end
		n_flag = result[7];
		z_flag = (result == 8'h00);
		v_flag = n_flag ^ c_flag;
	end

endmodule

`default_nettype wire

/* File: sim/srx_core_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

// --------
// Bus and flag checks at the core's ports
// --------
module srx_core_assertions (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] mem_rdata,
	input wire logic nonmaskable_ext_interrupt,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_rw,
	input wire logic [7:0] condition_code_register,
	input wire logic instr_done
);
	wire logic [7:0] cc;
	// Short alias keeps each flag relation on one line.
	assign cc = condition_code_register;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_xmask_rise;
		$rose(cc[6]) |-> $past(nonmaskable_ext_interrupt);
	endproperty
	a_xmask_rise: assert property (p_xmask_rise)
		else $error("x mask rose without interrupt");
	property p_dummy;
		!mem_rw |-> $past(mem_rw) && $past(mem_addr) == 16'hFFFF;
	endproperty
	a_dummy: assert property (p_dummy)
		else $error("write not preceded by dummy read");
	property p_oper;
		!mem_rw |-> $past(mem_rw, 2) && $past(mem_addr, 2) == mem_addr;
	endproperty
	a_oper: assert property (p_oper)
		else $error("write address differs from operand read");
	property p_wr_done;
		!mem_rw |=> instr_done && mem_rw;
	endproperty
	a_wr_done: assert property (p_wr_done)
		else $error("write is not the last cycle");
	// The carry is still the old one during the write cycle.
	property p_rot_data;
		!mem_rw |-> mem_wdata == {$past(mem_rdata[6:0], 2), cc[0]} ||
			mem_wdata == {cc[0], $past(mem_rdata[7:1], 2)};
	endproperty
	a_rot_data: assert property (p_rot_data)
		else $error("rotated byte wrong");
	// A rotate through carry keeps the count of ones in byte plus carry.
	property p_carry;
		!mem_rw |=> $countones({$past(mem_wdata), cc[0]}) ==
			$countones({$past(mem_rdata, 3), $past(cc[0])});
	endproperty
	a_carry: assert property (p_carry)
		else $error("carry not the bit shifted out");
	property p_nz;
		!mem_rw |=> cc[3] == $past(mem_wdata[7]) &&
			cc[2] == ($past(mem_wdata) == 8'h00);
	endproperty
	a_nz: assert property (p_nz)
		else $error("negative or zero flag wrong");
	property p_v;
		!mem_rw |=> cc[1] == (cc[3] ^ cc[0]);
	endproperty
	a_v: assert property (p_v)
		else $error("overflow flag wrong");
	property p_keep;
		!mem_rw |=> {cc[7], cc[5:4]} == $past({cc[7], cc[5:4]});
	endproperty
	a_keep: assert property (p_keep)
		else $error("untouched flags changed");

	c_write: cover property (!mem_rw);
	c_xmask: cover property ($rose(cc[6]));
	c_zero: cover property (instr_done && cc[2]);
endmodule

`default_nettype wire

/* File: sim/srx_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

// --------
// Zero-wait system memory
// --------
module srx_mem_model (
	input wire logic sys_clk,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_rw,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	// Zero fill so stray fetches decode as harmless unmapped opcodes.
	initial begin
		foreach (mem[i]) begin
			mem[i] = 8'h00;
		end
	end
	// Read data follows the address in the same cycle.
	assign mem_rdata = mem[mem_addr];
	// A low mem_rw at the edge stores the byte.
	always @(posedge sys_clk) begin
		if (!mem_rw) begin
			mem[mem_addr] <= mem_wdata;
		end
	end
endmodule

`default_nettype wire

/* File: sim/tb_stack_return_rotate_exec.sv */
`timescale 1ns/1ps
`default_nettype none

// --------
// Program-driven bench for the core
// --------
module tb_stack_return_rotate_exec;
	logic sys_clk, rst_n, nonmaskable_ext_interrupt, mem_rw, instr_done;
	logic [7:0] mem_rdata, mem_wdata, accumulator_one, accumulator_two;
	logic [7:0] condition_code_register;
	logic [15:0] mem_addr, index_x, index_y, stack_pointer, program_counter;
	int errors, num_checks;

	srx_core dut_u (.sys_clk, .rst_n, .mem_rdata, .nonmaskable_ext_interrupt,
		.mem_addr, .mem_wdata, .mem_rw, .accumulator_one, .accumulator_two,
		.condition_code_register, .index_x, .index_y, .stack_pointer,
		.program_counter, .instr_done);
	srx_mem_model mem_u (.sys_clk, .mem_addr, .mem_wdata, .mem_rw,
		.mem_rdata);

	// Free-running 40 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task print_verdict;
		if (errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Bytes are packed first-byte-highest so a program reads left to right.
	task ld(input logic [15:0] a, input logic [191:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			mem_u.mem[a + 16'(i)] = v[8 * (n - 1 - i) +: 8];
		end
	endtask

	// Counts edges up to the next done pulse; a hang ends the run.
	task step(input int n);
		int c;
		c = 0;
		do begin
			@(posedge sys_clk);
			#1;
			c++;
		end while (instr_done !== 1'b1 && c < 40);
		chk(32'(c), 32'(n));
		if (c >= 40) begin
			print_verdict();
		end
	endtask

	function automatic logic [31:0] abc();
		return {8'h00, accumulator_one, accumulator_two, condition_code_register};
	endfunction

	task t_ret_int;
		step(12);
		chk(abc(), 32'h00813501);
		chk({16'h0000, program_counter}, 32'h00000400);
		chk({index_x, index_y}, 32'h20003000);
		chk({stack_pointer, mem_addr}, 32'h01080400);
	endtask

	task t_ret_int_xkeep;
		step(12);
		chk(abc(), 32'h008135A1);
		chk({stack_pointer, mem_addr}, 32'h01110500);
	endtask

	task t_acc_rot;
		step(2);
		chk(abc(), 32'h000335A3);
		step(2);
		chk(abc(), 32'h00039AA9);
	endtask

	task t_sub_ba;
		step(2);
		chk(abc(), 32'h00699AA1);
	endtask

	task t_mem_rot;
		step(6);
		chk({16'h0000, mem_u.mem[16'h1000], condition_code_register},
			32'h000001A0);
		step(6);
		chk({16'h0000, mem_u.mem[16'h2010], condition_code_register},
			32'h000000A7);
		step(7);
		chk({16'h0000, mem_u.mem[16'h30FF], condition_code_register},
			32'h000001A3);
	endtask

	task t_rts_pull_y;
		step(5);
		chk({stack_pointer, mem_addr}, 32'h01130600);
		chk({16'h0000, program_counter}, 32'h00000600);
		step(6);
		chk({index_y, stack_pointer}, 32'h12340115);
		chk({mem_addr, 8'h00, condition_code_register}, 32'h060200A3);
	endtask

	task t_nonmaskable_ext_interrupt;
		nonmaskable_ext_interrupt = 1'b1;
		@(posedge sys_clk);
		#1;
		nonmaskable_ext_interrupt = 1'b0;
		chk({24'h000000, condition_code_register}, 32'h000000E3);
	endtask

	// Main sequence: load the program during reset, then run it.
	initial begin
		rst_n = 1'b0;
		nonmaskable_ext_interrupt = 1'b0;
		errors = 0;
		num_checks = 0;
		repeat (8) @(posedge sys_clk);
		#1;
		ld(16'h0000, 192'h3B, 1);
		ld(16'h0100, 176'h013581200030000400_E1358120003000050006001234, 22);
		ld(16'h0400, 192'h3B, 1);
		ld(16'h0500, 96'h4956107910006610_1869FF39, 12);
		ld(16'h0600, 16'h1838, 2);
		ld(16'h2010, 192'h01, 1);
		ld(16'h30FF, 192'h80, 1);
		chk({24'h000000, condition_code_register}, 32'h000000D0);
		rst_n = 1'b1;
		t_ret_int();
		t_ret_int_xkeep();
		t_acc_rot();
		t_sub_ba();
		t_mem_rot();
		t_rts_pull_y();
		t_nonmaskable_ext_interrupt();
		print_verdict();
	end
endmodule

bind srx_core srx_core_assertions chk_u (.sys_clk, .rst_n, .mem_rdata,
	.nonmaskable_ext_interrupt, .mem_addr, .mem_wdata, .mem_rw,
	.condition_code_register, .instr_done);

`default_nettype wire
